// file: pkg/skip_ops_pkg.sv
package skip_ops_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MEM_AW = 12;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ACCUM      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_BANK_PTR   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INDEX_BASE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INSTR      = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MEM_ADDR   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MEM_DATA   = 8'h1C;

    // instruction register fields
    localparam int unsigned INSTR_OP_BIT   = 0;
    localparam int unsigned INSTR_DEST_BIT = 1;
    localparam int unsigned INSTR_BANK_BIT = 2;
    localparam int unsigned INSTR_TWO_BIT  = 3;
    localparam int unsigned INSTR_F_LSB    = 8;

    // status register fields
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_SKIP_BIT  = 1;
    localparam int unsigned STAT_INDEX_BIT = 2;
    localparam int unsigned STAT_CYC_LSB   = 4;
    localparam int unsigned STAT_EFF_LSB   = 16;

    // ------------------------------------------------------------
    // reset values and addressing constants
    // ------------------------------------------------------------
    localparam logic [7:0]  ACCUM_RST      = 8'h00;
    localparam logic [3:0]  BANK_PTR_RST   = 4'h0;
    localparam logic [11:0] INDEX_BASE_RST = 12'h000;
    localparam logic [15:0] INSTR_RST      = 16'h0006;
    localparam logic [7:0]  INDEXED_MAX    = 8'h5F;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;

    // ------------------------------------------------------------
    // execution
    // ------------------------------------------------------------
    localparam logic       OP_COMPLEMENT = 1'b0;
    localparam logic       OP_COMPARE    = 1'b1;
    localparam logic [1:0] Q_DECODE      = 2'h0;
    localparam logic [1:0] Q_READ        = 2'h1;
    localparam logic [1:0] Q_PROCESS     = 2'h2;
    localparam logic [1:0] Q_WRITE       = 2'h3;
    localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
    localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

    typedef enum logic [1:0] {
        EXEC_IDLE,
        EXEC_RUN,
        EXEC_SKIP
    } exec_state_type;

endpackage

// file: core/quarter_sequencer.sv
`timescale 1ns/1ns
module quarter_sequencer
    import skip_ops_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_run,
    output logic [1:0]      o_phase,
    output logic            o_cycle_end
);

    logic [1:0] phase_ff;

    // phase restarts at decode whenever the engine is idle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_ff <= Q_DECODE;
        end else if (!i_run) begin
            phase_ff <= Q_DECODE;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign o_phase     = phase_ff;
    assign o_cycle_end = i_run && (phase_ff == Q_WRITE);

endmodule

// file: core/complement_compare_unit.sv
`timescale 1ns/1ns
module complement_compare_unit
    import skip_ops_pkg::*;
(
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_n,
    input  wire logic [ADDR_W-1:0]   i_axi_awaddr,
    input  wire logic                i_axi_awvalid,
    output logic                     o_axi_awready,
    input  wire logic [DATA_W-1:0]   i_axi_wdata,
    input  wire logic [3:0]          i_axi_wstrb,
    input  wire logic                i_axi_wvalid,
    output logic                     o_axi_wready,
    output logic [1:0]               o_axi_bresp,
    output logic                     o_axi_bvalid,
    input  wire logic                i_axi_bready,
    input  wire logic [ADDR_W-1:0]   i_axi_araddr,
    input  wire logic                i_axi_arvalid,
    output logic                     o_axi_arready,
    output logic [DATA_W-1:0]        o_axi_rdata,
    output logic [1:0]               o_axi_rresp,
    output logic                     o_axi_rvalid,
    input  wire logic                i_axi_rready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]          data_mem [0:(1<<MEM_AW)-1];
    logic                awready_ff;
    logic                wready_ff;
    logic                aw_held_ff;
    logic                w_held_ff;
    logic [ADDR_W-1:0]   aw_addr_ff;
    logic [DATA_W-1:0]   w_data_ff;
    logic [3:0]          w_strb_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;
    logic                arready_ff;
    logic                rvalid_ff;
    logic [DATA_W-1:0]   rdata_ff;
    logic [1:0]          rresp_ff;

    logic                ext_en_ff;
    logic [7:0]          accum_ff;
    logic [3:0]          bank_ptr_ff;
    logic [11:0]         index_base_ff;
    logic [15:0]         instr_ff;
    logic [MEM_AW-1:0]   mem_addr_ff;
    logic                start_ff;

    exec_state_type      state_ff;
    logic [MEM_AW-1:0]   eff_addr_ff;
    logic                indexed_ff;
    logic [7:0]          operand_ff;
    logic [7:0]          result_ff;
    logic                equal_ff;
    logic                skipped_ff;
    logic [1:0]          skip_left_ff;
    logic [3:0]          cycles_ff;

    logic [1:0]          phase;
    logic                cycle_end;
    logic                commit;
    logic                busy;
    logic [DATA_W-1:0]   merged;
    logic [DATA_W-1:0]   old_word;
    logic [7:0]          f_field;
    logic [7:0]          difference;
    logic                write_phase;
    logic [DATA_W-1:0]   status_word;
    logic [MEM_AW-1:0]   nxt_eff_addr;
    logic                nxt_indexed;

    assign busy        = (state_ff != EXEC_IDLE);
    assign commit      = aw_held_ff && w_held_ff && !bvalid_ff;
    assign f_field     = instr_ff[INSTR_F_LSB +: 8];
    assign write_phase = (state_ff == EXEC_RUN) && (phase == Q_WRITE);

    quarter_sequencer u_seq (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_run       (busy),
        .o_phase     (phase),
        .o_cycle_end (cycle_end)
    );

    // ------------------------------------------------------------
    // operand address
    // ------------------------------------------------------------
    always_comb begin
        nxt_indexed = 1'b0;
        if (instr_ff[INSTR_BANK_BIT]) begin
            nxt_eff_addr = {bank_ptr_ff, f_field};
        end else if (ext_en_ff && (f_field <= INDEXED_MAX)) begin
            nxt_eff_addr = index_base_ff + {4'h0, f_field};
            nxt_indexed  = 1'b1;
        end else if (f_field <= INDEXED_MAX) begin
            nxt_eff_addr = {ACCESS_LO_BANK, f_field};
        end else begin
            nxt_eff_addr = {ACCESS_HI_BANK, f_field};
        end
    end

    // ------------------------------------------------------------
    // bus write side
    // ------------------------------------------------------------
    always_comb begin
        unique case (aw_addr_ff)
            OFS_CTRL:       old_word = {31'h0, ext_en_ff};
            OFS_ACCUM:      old_word = {24'h0, accum_ff};
            OFS_BANK_PTR:   old_word = {28'h0, bank_ptr_ff};
            OFS_INDEX_BASE: old_word = {20'h0, index_base_ff};
            OFS_INSTR:      old_word = {16'h0, instr_ff};
            OFS_MEM_ADDR:   old_word = {20'h0, mem_addr_ff};
            OFS_MEM_DATA:   old_word = {24'h0, data_mem[mem_addr_ff]};
            default:        old_word = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = w_strb_ff[i] ? w_data_ff[i*8 +: 8]
                                            : old_word[i*8 +: 8];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= '0;
            w_strb_ff  <= '0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            if (i_axi_awvalid && awready_ff) begin
                aw_addr_ff <= {i_axi_awaddr[ADDR_W-1:2], 2'h0};
                aw_held_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (i_axi_wvalid && wready_ff) begin
                w_data_ff <= i_axi_wdata;
                w_strb_ff <= i_axi_wstrb;
                w_held_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (commit) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (aw_addr_ff > OFS_MEM_DATA) ? RESP_SLVERR
                                                         : RESP_OKAY;
            end
            if (bvalid_ff && i_axi_bready) begin
                bvalid_ff  <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // configuration; writes while busy are dropped so an operand
    // cannot shift under a running instruction
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_en_ff     <= 1'b0;
            bank_ptr_ff   <= BANK_PTR_RST;
            index_base_ff <= INDEX_BASE_RST;
            instr_ff      <= INSTR_RST;
            mem_addr_ff   <= '0;
            start_ff      <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (commit && !busy && !start_ff) begin
                unique case (aw_addr_ff)
                    OFS_CTRL:       ext_en_ff     <= merged[0];
                    OFS_BANK_PTR:   bank_ptr_ff   <= merged[3:0];
                    OFS_INDEX_BASE: index_base_ff <= merged[11:0];
                    OFS_MEM_ADDR:   mem_addr_ff   <= merged[11:0];
                    OFS_INSTR: begin
                        instr_ff <= merged[15:0];
                        start_ff <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and data memory
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            accum_ff <= ACCUM_RST;
        end else if (write_phase && instr_ff[INSTR_OP_BIT] == OP_COMPLEMENT
                     && !instr_ff[INSTR_DEST_BIT]) begin
            accum_ff <= result_ff;
        end else if (commit && !busy && !start_ff
                     && aw_addr_ff == OFS_ACCUM) begin
            accum_ff <= merged[7:0];
        end
    end

    // compare never reaches these writes in its last phase
    always_ff @(posedge i_ref_clk) begin
        if (write_phase && instr_ff[INSTR_OP_BIT] == OP_COMPLEMENT
            && instr_ff[INSTR_DEST_BIT]) begin
            data_mem[eff_addr_ff] <= result_ff;
        end else if (commit && !busy && !start_ff
                     && aw_addr_ff == OFS_MEM_DATA) begin
            data_mem[mem_addr_ff] <= merged[7:0];
        end
    end

    // ------------------------------------------------------------
    // execution engine
    // ------------------------------------------------------------
    assign difference = operand_ff - accum_ff;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff     <= EXEC_IDLE;
            eff_addr_ff  <= '0;
            indexed_ff   <= 1'b0;
            operand_ff   <= '0;
            result_ff    <= '0;
            equal_ff     <= 1'b0;
            skipped_ff   <= 1'b0;
            skip_left_ff <= '0;
            cycles_ff    <= '0;
        end else begin
            unique case (state_ff)
                EXEC_IDLE: begin
                    if (start_ff) begin
                        state_ff   <= EXEC_RUN;
                        cycles_ff  <= '0;
                        skipped_ff <= 1'b0;
                        equal_ff   <= 1'b0;
                    end
                end
                EXEC_RUN: begin
                    unique case (phase)
                        Q_DECODE: begin
                            eff_addr_ff <= nxt_eff_addr;
                            indexed_ff  <= nxt_indexed;
                        end
                        Q_READ:    operand_ff <= data_mem[eff_addr_ff];
                        Q_PROCESS: begin
                            result_ff <= ~operand_ff;
                            equal_ff  <= (difference == 8'h00);
                        end
                        Q_WRITE: begin
                            cycles_ff <= cycles_ff + 4'h1;
                            if (instr_ff[INSTR_OP_BIT] == OP_COMPARE
                                && equal_ff) begin
                                state_ff     <= EXEC_SKIP;
                                skipped_ff   <= 1'b1;
                                skip_left_ff <= instr_ff[INSTR_TWO_BIT]
                                              ? SKIP_TWO_WORD
                                              : SKIP_ONE_WORD;
                            end else begin
                                state_ff <= EXEC_IDLE;
                            end
                        end
                    endcase
                end
                EXEC_SKIP: begin
                    // each discarded word costs one no_operation cycle
                    if (cycle_end) begin
                        cycles_ff    <= cycles_ff + 4'h1;
                        skip_left_ff <= skip_left_ff - 2'h1;
                        if (skip_left_ff == SKIP_ONE_WORD) begin
                            state_ff <= EXEC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus read side
    // ------------------------------------------------------------
    always_comb begin
        status_word = 32'h0;
        status_word[STAT_BUSY_BIT]         = busy || start_ff;
        status_word[STAT_SKIP_BIT]         = skipped_ff;
        status_word[STAT_INDEX_BIT]        = indexed_ff;
        status_word[STAT_CYC_LSB +: 4]     = cycles_ff;
        status_word[STAT_EFF_LSB +: MEM_AW] = eff_addr_ff;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end else if (i_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rresp_ff   <= RESP_OKAY;
            unique case ({i_axi_araddr[ADDR_W-1:2], 2'h0})
                OFS_CTRL:       rdata_ff <= {31'h0, ext_en_ff};
                OFS_ACCUM:      rdata_ff <= {24'h0, accum_ff};
                OFS_BANK_PTR:   rdata_ff <= {28'h0, bank_ptr_ff};
                OFS_INDEX_BASE: rdata_ff <= {20'h0, index_base_ff};
                OFS_INSTR:      rdata_ff <= {16'h0, instr_ff};
                OFS_STATUS:     rdata_ff <= status_word;
                OFS_MEM_ADDR:   rdata_ff <= {20'h0, mem_addr_ff};
                OFS_MEM_DATA:   rdata_ff <= {24'h0, data_mem[mem_addr_ff]};
                default: begin
                    rdata_ff <= 32'h0;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && i_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign o_axi_awready = awready_ff;
    assign o_axi_wready  = wready_ff;
    assign o_axi_bvalid  = bvalid_ff;
    assign o_axi_bresp   = bresp_ff;
    assign o_axi_arready = arready_ff;
    assign o_axi_rvalid  = rvalid_ff;
    assign o_axi_rdata   = rdata_ff;
    assign o_axi_rresp   = rresp_ff;

endmodule

// file: dv/complement_compare_assertions.sv
`timescale 1ns/1ns
module complement_compare_checker
    import skip_ops_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_rst_n,
    input wire logic [ADDR_W-1:0] i_axi_awaddr,
    input wire logic              i_axi_awvalid,
    input wire logic              o_axi_awready,
    input wire logic [DATA_W-1:0] i_axi_wdata,
    input wire logic [3:0]        i_axi_wstrb,
    input wire logic              i_axi_wvalid,
    input wire logic              o_axi_wready,
    input wire logic [1:0]        o_axi_bresp,
    input wire logic              o_axi_bvalid,
    input wire logic              i_axi_bready,
    input wire logic [ADDR_W-1:0] i_axi_araddr,
    input wire logic              i_axi_arvalid,
    input wire logic              o_axi_arready,
    input wire logic [DATA_W-1:0] o_axi_rdata,
    input wire logic [1:0]        o_axi_rresp,
    input wire logic              o_axi_rvalid,
    input wire logic              i_axi_rready
);
    logic [ADDR_W-1:0] ar_addr_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] instr_ff;
    logic [3:0]        bank_ff;

    // ----------------------------------------
    // shadow of what software wrote
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_addr_ff <= '0;
            wdata_ff   <= '0;
        end else begin
            if (i_axi_awvalid && o_axi_awready) aw_addr_ff <= i_axi_awaddr;
            if (i_axi_wvalid && o_axi_wready) wdata_ff <= i_axi_wdata;
        end
    end

    // limitation: a write dropped while busy would still be shadowed
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            instr_ff <= {16'h0, INSTR_RST};
            bank_ff  <= BANK_PTR_RST;
        end else if ($rose(o_axi_bvalid)) begin
            if (aw_addr_ff[7:2] == OFS_INSTR[7:2]) instr_ff <= wdata_ff;
            if (aw_addr_ff[7:2] == OFS_BANK_PTR[7:2]) bank_ff <= wdata_ff[3:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) ar_addr_ff <= '0;
        else if (i_axi_arvalid && o_axi_arready) ar_addr_ff <= i_axi_araddr;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence both_taken;
        !o_axi_awready && !o_axi_wready && !o_axi_bvalid;
    endsequence

    sequence status_done;
        o_axi_rvalid && ar_addr_ff[7:2] == OFS_STATUS[7:2]
            && !o_axi_rdata[STAT_BUSY_BIT] && o_axi_rdata[7:4] != 4'h0;
    endsequence

    write_answer_a: assert property (both_taken |=> o_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (
        i_axi_arvalid && o_axi_arready |=> o_axi_rvalid && !o_axi_arready)
        else $error("read data late");
    read_block_a: assert property (o_axi_rvalid |-> !o_axi_arready)
        else $error("address taken while data pending");
    unmapped_read_a: assert property (o_axi_rvalid && ar_addr_ff > 8'h1F
        |-> o_axi_rresp == RESP_SLVERR && o_axi_rdata == '0)
        else $error("unmapped read not refused");
    single_cycle_a: assert property (
        status_done ##0 !o_axi_rdata[STAT_SKIP_BIT] |-> o_axi_rdata[7:4] == 4'h1)
        else $error("unskipped op not one cycle");
    skip_cycles_a: assert property (
        status_done ##0 o_axi_rdata[STAT_SKIP_BIT] |-> o_axi_rdata[7:4]
            == (instr_ff[INSTR_TWO_BIT] ? 4'h3 : 4'h2))
        else $error("skip cycle count wrong");
    skip_cause_a: assert property (
        status_done ##0 o_axi_rdata[STAT_SKIP_BIT]
            |-> instr_ff[INSTR_OP_BIT] == OP_COMPARE)
        else $error("skip without compare");
    bank_address_a: assert property (
        status_done ##0 instr_ff[INSTR_BANK_BIT] |-> !o_axi_rdata[2]
            && o_axi_rdata[27:16] == {bank_ff, instr_ff[15:8]})
        else $error("banked address wrong");
    index_range_a: assert property (
        status_done ##0 o_axi_rdata[STAT_INDEX_BIT] |-> !instr_ff[2]
            && instr_ff[15:8] <= INDEXED_MAX)
        else $error("indexed mode out of range");
endmodule

// file: dv/complement_and_compare_skip_ops_tb.sv
`timescale 1ns/1ns
module complement_and_compare_skip_ops_tb import skip_ops_pkg::*;;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0]  resp;
    } note_type;
    localparam logic [31:0] ALL  = 32'hFFFFFFFF;
    localparam logic [31:0] BYTE = 32'h000000FF;
    localparam logic [31:0] STM  = 32'h0FFF00F7;
    localparam logic [1:0]  OK   = RESP_OKAY;

    logic i_ref_clk = 1'h0, i_rst_n = 1'h0;
    logic i_axi_awvalid = 1'h0, i_axi_wvalid = 1'h0, i_axi_bready = 1'h0;
    logic i_axi_arvalid = 1'h0, i_axi_rready = 1'h0;
    logic [7:0] i_axi_awaddr = '0, i_axi_araddr = '0;
    logic [31:0] i_axi_wdata = '0, last_rdata;
    logic [3:0] i_axi_wstrb = 4'hF;
    wire o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
    wire o_axi_rvalid;
    wire [1:0] o_axi_bresp, o_axi_rresp;
    wire [31:0] o_axi_rdata;
    note_type rd_q[$];
    logic [1:0] wr_q[$];
    int num_errors = 0;
    int comparisons = 0;

    complement_compare_unit dut_u (.i_ref_clk, .i_rst_n, .i_axi_awaddr,
        .i_axi_awvalid, .o_axi_awready, .i_axi_wdata, .i_axi_wstrb,
        .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid,
        .i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready,
        .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid, .i_axi_rready);

    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic miss(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        num_errors++;
        if (msg == "timeout") report_and_stop();
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) miss("write response");
    endtask

    task automatic chk_read(input logic [31:0] got, input logic [1:0] r,
                            input note_type n);
        comparisons++;
        if ((got & n.mask) !== (n.data & n.mask) || r !== n.resp) begin
            miss("read value");
        end
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (o_axi_bvalid && i_axi_bready) chk_resp(o_axi_bresp, wr_q.pop_front());
        if (o_axi_rvalid && i_axi_rready) begin
            chk_read(o_axi_rdata, o_axi_rresp, rd_q.pop_front());
        end
    end

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    // extra edge at the end keeps a ready from being set twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        wr_q.push_back(er);
        i_axi_awaddr <= a;
        i_axi_wdata <= d;
        i_axi_awvalid <= 1'h1;
        i_axi_wvalid <= 1'h1;
        i_axi_bready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge i_ref_clk);
            if (o_axi_awready) i_axi_awvalid <= 1'h0;
            if (o_axi_wready) i_axi_wvalid <= 1'h0;
            if (o_axi_bvalid) break;
        end
        i_axi_bready <= 1'h0;
        @(posedge i_ref_clk);
        if (n == 64) miss("timeout");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
        int n;
        rd_q.push_back('{e, m, er});
        i_axi_araddr <= a;
        i_axi_arvalid <= 1'h1;
        i_axi_rready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge i_ref_clk);
            if (o_axi_arready) i_axi_arvalid <= 1'h0;
            if (o_axi_rvalid) break;
        end
        last_rdata = o_axi_rdata;
        i_axi_rready <= 1'h0;
        @(posedge i_ref_clk);
        if (n == 64) miss("timeout");
    endtask

    task automatic run(input logic [31:0] instr);
        int n;
        wr(OFS_INSTR, instr, OK);
        for (n = 0; n < 32; n++) begin
            rd(OFS_STATUS, '0, '0, OK);
            if (last_rdata[STAT_BUSY_BIT] === 1'h0) break;
        end
        if (n == 32) miss("timeout");
    endtask

    task automatic mem_put(input logic [11:0] a, input logic [7:0] v);
        wr(OFS_MEM_ADDR, {20'h0, a}, OK);
        wr(OFS_MEM_DATA, {24'h0, v}, OK);
    endtask

    function automatic logic [31:0] ins(input logic op, dst, bnk, two,
                                        input logic [7:0] f);
        return {16'h0, f, 4'h0, two, bnk, dst, op};
    endfunction

    function automatic logic [31:0] stat(input logic sk, ix,
                                         input logic [3:0] cy,
                                         input logic [11:0] ea);
        return {4'h0, ea, 8'h0, cy, 1'h0, ix, sk, 1'h0};
    endfunction

    initial begin
        logic [7:0]  v, f, acc;
        logic [3:0]  bp;
        logic [11:0] base, ea;
        int i;
        void'($urandom(32'hC045C500));
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'h1;
        @(posedge i_ref_clk);
        rd(OFS_INSTR, {16'h0, INSTR_RST}, ALL, OK);
        rd(OFS_STATUS, '0, ALL, OK);
        wr(8'h40, $urandom, RESP_SLVERR);
        rd(8'h40, '0, ALL, RESP_SLVERR);
        // complement back to a banked file register
        {v, f, bp} = $urandom;
        wr(OFS_BANK_PTR, {28'h0, bp}, OK);
        mem_put({bp, f}, v);
        run(ins(OP_COMPLEMENT, 1'h1, 1'h1, 1'h0, f));
        rd(OFS_STATUS, stat(1'h0, 1'h0, 4'h1, {bp, f}), STM, OK);
        rd(OFS_MEM_DATA, {24'h0, ~v}, BYTE, OK);
        // complement into accumulator, upper access half
        {v, f} = $urandom;
        f[7] = 1'h1;
        wr(OFS_ACCUM, {24'h0, v}, OK);
        mem_put({ACCESS_HI_BANK, f}, v);
        run(ins(OP_COMPLEMENT, 1'h0, 1'h0, 1'h0, f));
        rd(OFS_ACCUM, {24'h0, ~v}, BYTE, OK);
        rd(OFS_MEM_DATA, {24'h0, v}, BYTE, OK);
        rd(OFS_STATUS, stat(1'h0, 1'h0, 4'h1, {ACCESS_HI_BANK, f}), STM, OK);
        // indexed boundary: 0x5F with and without extension, then 0x60
        base = $urandom;
        wr(OFS_INDEX_BASE, {20'h0, base}, OK);
        for (i = 0; i < 3; i++) begin
            f = (i == 2) ? 8'h60 : INDEXED_MAX;
            ea = (i == 1) ? base + {4'h0, f}
               : {(i == 2) ? ACCESS_HI_BANK : ACCESS_LO_BANK, f};
            v = $urandom;
            wr(OFS_CTRL, {31'h0, i != 0}, OK);
            mem_put(ea, v);
            run(ins(OP_COMPLEMENT, 1'h1, 1'h0, 1'h0, f));
            rd(OFS_STATUS, stat(1'h0, i == 1, 4'h1, ea), STM, OK);
            rd(OFS_MEM_DATA, {24'h0, ~v}, BYTE, OK);
        end
        // compare: unequal/equal, one-word/two-word follower
        for (i = 0; i < 4; i++) begin
            {v, f} = $urandom;
            acc = (i % 2 == 1) ? v : ~v;
            mem_put({bp, f}, v);
            wr(OFS_ACCUM, {24'h0, acc}, OK);
            run(ins(OP_COMPARE, 1'h1, 1'h1, i > 1, f));
            rd(OFS_STATUS, stat(i % 2 == 1, 1'h0, (i % 2 == 0) ? 4'h1
               : (i > 1) ? 4'h3 : 4'h2, {bp, f}), STM, OK);
            rd(OFS_MEM_DATA, {24'h0, v}, BYTE, OK);
            rd(OFS_ACCUM, {24'h0, acc}, BYTE, OK);
        end
        report_and_stop();
    end
endmodule

bind complement_compare_unit complement_compare_checker chk_u (.i_ref_clk,
    .i_rst_n, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
    .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid,
    .i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready,
    .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid, .i_axi_rready);
